// ===== logic/cebp_pins.sv
// Card and expansion bus pin sharing and cycle control
`timescale 1ns/1ps
`default_nettype none
`include "cebp_consts.svh"
module cebp_pins
   import cebp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        busEnable,
   input  wire logic [1:0]  readyPinSelect,
   input  wire logic        wideIoPinSelect,
   input  wire logic [1:0]  batteryPinSelect,
   input  wire logic        detectPinSelect,
   input  wire logic        bufEnAPinSelect,
   input  wire logic        slotAIoMode,
   input  wire logic        slotBIoMode,
   input  wire logic        cycleReq,
   input  wire logic        cycleIsIo,
   input  wire logic        cycleWrite,
   input  wire logic        cycleCard,
   input  wire logic        cycleSlotB,
   input  wire logic        cycleLowByte,
   input  wire logic        cycleHighByte,
   input  wire logic        coreDmaAck0N,
   output logic             cycleBusy,
   output logic             cycleDone,
   input  wire logic        channelReady,
   input  wire logic        channelCheckN,
   input  wire logic [5:0]  periphIrqInputs,
   input  wire logic        dmaRequest1,
   input  wire logic        dmaRequest3,
   input  wire logic        cardReadyA,
   input  wire logic [1:0]  cardDetectAN,
   input  wire logic        kbdSerialInN,
   input  wire logic        kbdClockN,
   input  wire logic [1:0]  cardBatteryStatusA,
   output logic             ioReadStrobeN,
   output logic             ioReadStrobeOe,
   output logic             ioWriteStrobeN,
   output logic             ioWriteStrobeOe,
   output logic             cardLowByteSelN,
   output logic             cardHighByteSelN,
   output logic             dmaAck0N,
   output logic             dmaAck0Oe,
   output logic             nmiRequest,
   output logic [5:0]       irqRequest,
   output logic             dmaReq1,
   output logic             dmaReq3,
   output logic             ioPortWide,
   output logic [1:0]       cardIrq,
   output logic [1:0]       cardReadyStatus,
   output logic [1:0]       cardPresent,
   output logic [1:0]       statusChange,
   output logic [1:0]       cardAudio,
   output logic [3:0]       statusDataBattery
);
   function automatic logic bothLow(input logic a, input logic b);
      bothLow = !a && !b;
   endfunction

   logic [`CEBP_SYNC_W-1:0] pinSync;

   cebp_sync #(.W(`CEBP_SYNC_W), .RESET_VAL(`CEBP_SYNC_INIT)) u_sync
   (
      .clk      (clk),
      .rst      (rst),
      .async_in ({cardBatteryStatusA, kbdClockN, kbdSerialInN,
                  cardDetectAN, cardReadyA, dmaRequest3, dmaRequest1,
                  periphIrqInputs, channelCheckN, channelReady}),
      .sync_out (pinSync)
   );

   wire       readyS   = pinSync[`CEBP_S_READY];
   wire       checkS   = pinSync[`CEBP_S_CHECK];
   wire [5:0] irqS     = pinSync[`CEBP_S_IRQ +: 6];
   wire       drq1S    = pinSync[`CEBP_S_DMA_REQUEST_1];
   wire       drq3S    = pinSync[`CEBP_S_DMA_REQUEST_3];
   wire       rdyAS    = pinSync[`CEBP_S_CRDYA];
   wire [1:0] detAS    = pinSync[`CEBP_S_DETA +: 2];
   wire       kbdDS    = pinSync[`CEBP_S_KBDD];
   wire       kbdCS    = pinSync[`CEBP_S_KBDC];
   wire [1:0] batAS    = pinSync[`CEBP_S_BATA +: 2];

   // Pin takeover decode
   wire irq2IsReadyB = readyPinSelect == CEBP_IRQ2_READY_B;
   wire irq2IsWide   = readyPinSelect == CEBP_IRQ2_WIDE_IO;
   wire irq2Taken    = readyPinSelect != CEBP_IRQ2_NORMAL;
   wire bat1BSel     = batteryPinSelect[`CEBP_BATSEL_DMA_REQUEST_1];
   wire bat2BSel     = batteryPinSelect[`CEBP_BATSEL_DMA_REQUEST_3];
   wire rdyBS        = irq2IsReadyB ? irqS[0] : 1'b1;
   wire [1:0] batBS  = {bat2BSel ? drq3S : 1'b1, bat1BSel ? drq1S : 1'b1};

   wire       nmi_d  = busEnable && !wideIoPinSelect && !checkS;
   wire [5:0] irq_d  = busEnable ? (irqS & {5'h1F, !irq2Taken}) : 6'h00;
   wire       wide_d = wideIoPinSelect ? !checkS : (irq2IsWide && !irqS[0]);
   wire [1:0] ioMode = {slotBIoMode, slotAIoMode};
   wire [1:0] rdyS   = {rdyBS, rdyAS};
   wire [1:0] cirq_d = ioMode & ~rdyS;
   wire [1:0] crdy_d = ~ioMode & rdyS;
   // Without the keyboard pins each slot A detect carries one card's AND
   wire presA_d = detectPinSelect ? bothLow(detAS[0], detAS[1]) : !detAS[0];
   wire presB_d = detectPinSelect ? bothLow(kbdDS, kbdCS) : !detAS[1];
   wire [3:0] bat_d = {bat2BSel ? batBS[1] : 1'b0,
                       bat1BSel ? batBS[0] : 1'b0, batAS};
   wire [1:0] stsc_d = ioMode & ~{batBS[0], batAS[0]};
   wire [1:0] aud_d  = ioMode & ~{batBS[1], batAS[1]};

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         nmiRequest        <= 1'b0;
         irqRequest        <= 6'h00;
         dmaReq1           <= 1'b0;
         dmaReq3           <= 1'b0;
         ioPortWide        <= 1'b0;
         cardIrq           <= 2'h0;
         cardReadyStatus   <= 2'h0;
         cardPresent       <= 2'h0;
         statusChange      <= 2'h0;
         cardAudio         <= 2'h0;
         statusDataBattery <= 4'h0;
      end
      else
      begin
         nmiRequest        <= nmi_d;
         irqRequest        <= irq_d;
         dmaReq1           <= busEnable && drq1S && !bat1BSel;
         dmaReq3           <= busEnable && drq3S && !bat2BSel;
         ioPortWide        <= wide_d;
         cardIrq           <= cirq_d;
         cardReadyStatus   <= crdy_d;
         cardPresent       <= {presB_d, presA_d};
         statusChange      <= stsc_d;
         cardAudio         <= aud_d;
         statusDataBattery <= bat_d;
      end
   end

   cebp_state_t state_q;
   cebp_state_t state_d;
   logic [`CEBP_CNT_W-1:0] cnt_q;
   logic [`CEBP_CNT_W-1:0] cnt_d;
   logic curIo_q;
   logic curWr_q;
   logic curCard_q;
   logic curB_q;
   logic curLo_q;
   logic curHi_q;

   wire cmdEnd = cnt_q == `CEBP_CNT_W'(1);

   always_comb
   begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         CEBP_IDLE:
         begin
            if (cycleReq)
            begin
               state_d = CEBP_RUN;
               cnt_d   = `CEBP_CNT_W'(`CEBP_CMD_CYC);
            end
         end
         CEBP_RUN:
         begin
            cnt_d = cnt_q - `CEBP_CNT_W'(1);
            if (cmdEnd)
               state_d = readyS ? CEBP_DONE : CEBP_WAIT;
         end
         CEBP_WAIT:
         begin
            if (readyS)
               state_d = CEBP_DONE;
         end
         default:
            state_d = CEBP_IDLE;
      endcase
   end

   wire active_d = state_d == CEBP_RUN || state_d == CEBP_WAIT;
   wire start    = state_q == CEBP_IDLE && cycleReq;
   wire nIo      = start ? cycleIsIo     : curIo_q;
   wire nWr      = start ? cycleWrite    : curWr_q;
   wire nCard    = start ? cycleCard     : curCard_q;
   wire nB       = start ? cycleSlotB    : curB_q;
   wire nLo      = start ? cycleLowByte  : curLo_q;
   wire nHi      = start ? cycleHighByte : curHi_q;
   wire bufA_d   = active_d && nCard && !nB;

   assign cycleBusy = state_q != CEBP_IDLE;
   assign cycleDone = state_q == CEBP_DONE;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_q          <= CEBP_IDLE;
         cnt_q            <= '0;
         {curIo_q, curWr_q, curCard_q} <= 3'h0;
         {curB_q, curLo_q, curHi_q}    <= 3'h0;
         ioReadStrobeN    <= 1'b1;
         ioWriteStrobeN   <= 1'b1;
         ioReadStrobeOe   <= 1'b0;
         ioWriteStrobeOe  <= 1'b0;
         cardLowByteSelN  <= 1'b1;
         cardHighByteSelN <= 1'b1;
         dmaAck0N         <= 1'b1;
         dmaAck0Oe        <= 1'b0;
      end
      else
      begin
         state_q          <= state_d;
         cnt_q            <= cnt_d;
         {curIo_q, curWr_q, curCard_q} <= {nIo, nWr, nCard};
         {curB_q, curLo_q, curHi_q}    <= {nB, nLo, nHi};
         // Also the card I/O commands, so no separate card pins
         ioReadStrobeN    <= !(active_d && nIo && !nWr);
         ioWriteStrobeN   <= !(active_d && nIo && nWr);
         ioReadStrobeOe   <= busEnable;
         ioWriteStrobeOe  <= busEnable;
         cardLowByteSelN  <= !(active_d && nCard && nLo);
         cardHighByteSelN <= !(active_d && nCard && nHi);
         dmaAck0N         <= bufEnAPinSelect ? !bufA_d : coreDmaAck0N;
         dmaAck0Oe        <= bufEnAPinSelect || busEnable;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   nmi_gate_a: assert property (!busEnable |=> !nmiRequest)
      else $error("NMI raised while bus disabled");
   wait_hold_a: assert property (state_q == CEBP_WAIT && !readyS
      |=> state_q == CEBP_WAIT)
      else $error("Cycle ended while channel not ready");
   // Ready is judged on the last command cycle, three after the take
   cycle_len_a: assert property (start ##3 readyS |=> cycleDone)
      else $error("Unstretched cycle has wrong length");
   wide_io_a: assert property (wideIoPinSelect && !checkS
      |=> ioPortWide && !nmiRequest)
      else $error("Wide I/O not taken from check pin");
   rd_float_a: assert property (!busEnable |=> !ioReadStrobeOe)
      else $error("Read strobe driven with bus disabled");
   wr_cycle_a: assert property (!ioWriteStrobeN |-> curIo_q && curWr_q
      && (state_q == CEBP_RUN || state_q == CEBP_WAIT))
      else $error("Write strobe outside an I/O write");
   card_irq_a: assert property (slotAIoMode && !rdyAS
      |=> cardIrq[0] && !cardReadyStatus[0])
      else $error("Slot A interrupt not taken from ready");
   irq_gate_a: assert property (!busEnable |=> irqRequest == 6'h00)
      else $error("IRQ passed while bus disabled");
   det_b_a: assert property (detectPinSelect && bothLow(kbdDS, kbdCS)
      |=> cardPresent[1])
      else $error("Slot B presence missed");
   low_sel_a: assert property (!cardLowByteSelN |-> curCard_q && curLo_q)
      else $error("Low byte select outside a card access");
   buf_en_a: assert property (bufEnAPinSelect && state_q == CEBP_WAIT
      && curCard_q && !curB_q |-> !dmaAck0N)
      else $error("Slot A buffer enable dropped mid cycle");

   wait_seen_c: cover property (state_q == CEBP_WAIT ##1 cycleDone);
   io_read_c:   cover property (!ioReadStrobeN ##[1:20] cycleDone);
   card_cyc_c:  cover property (!cardLowByteSelN && !cardHighByteSelN);
endmodule
`default_nettype wire

// ===== logic/cebp_consts.svh
// Constants for the card and expansion bus pin logic
`ifndef CEBP_CONSTS_SVH
`define CEBP_CONSTS_SVH

`define CEBP_CLK_NS       25
`define CEBP_CMD_NS       75
`define CEBP_CMD_CYC      ((`CEBP_CMD_NS + `CEBP_CLK_NS - 1) / `CEBP_CLK_NS)
`define CEBP_CNT_W        4
`define CEBP_SYNC_W       17
`define CEBP_SYNC_INIT    17'h1FC03
`define CEBP_S_READY      0
`define CEBP_S_CHECK      1
`define CEBP_S_IRQ        2
`define CEBP_S_DMA_REQUEST_1       8
`define CEBP_S_DMA_REQUEST_3       9
`define CEBP_S_CRDYA      10
`define CEBP_S_DETA       11
`define CEBP_S_KBDD       13
`define CEBP_S_KBDC       14
`define CEBP_S_BATA       15
`define CEBP_BATSEL_DMA_REQUEST_1  0
`define CEBP_BATSEL_DMA_REQUEST_3  1

`endif

// ===== logic/cebp_pkg.sv
// Types for the card and expansion bus pin logic
package cebp_pkg;
   typedef enum logic [1:0] {CEBP_IDLE, CEBP_RUN, CEBP_WAIT, CEBP_DONE}
      cebp_state_t;
   typedef enum logic [1:0] {
      CEBP_IRQ2_NORMAL,
      CEBP_IRQ2_READY_B,
      CEBP_IRQ2_WIDE_IO,
      CEBP_IRQ2_SPARE
   } cebp_rdysel_t;
endpackage

// ===== logic/cebp_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module cebp_sync
#(
   parameter int              W         = 1,
   parameter logic [W-1:0]    RESET_VAL = '0
)
(
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic [W-1:0]  async_in,
   output var  logic [W-1:0]  sync_out
);
   logic [W-1:0] stage1_q;

   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         always_ff @(posedge clk)
         begin
            if (rst)
            begin
               stage1_q[i] <= RESET_VAL[i];
               sync_out[i] <= RESET_VAL[i];
            end
            else
            begin
               stage1_q[i] <= async_in[i];
               sync_out[i] <= stage1_q[i];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ===== test/cebp_far_model.sv
// Model of a slow bus peripheral and the card detect wiring
`timescale 1ns/1ps
`default_nettype none
module cebp_far_model
(
   input  wire logic       clk,
   input  wire logic       ioReadStrobeN,
   input  wire logic       ioWriteStrobeN,
   input  wire logic [3:0] waitLen,
   input  wire logic       detSel,
   input  wire logic [1:0] detA,
   input  wire logic [1:0] detB,
   input  wire logic       cardLowByteSelN,
   input  wire logic       cardHighByteSelN,
   input  wire logic       bufEnAN,
   output wire logic       channelReady,
   output wire logic [1:0] cardDetectAN,
   output wire logic [1:0] cardASelN
);
   logic [3:0] cnt_q;
   logic       seen_q;
   wire        strobeOn = !(ioReadStrobeN && ioWriteStrobeN);
   initial
   begin
      cnt_q = 4'h0;
      seen_q = 1'b0;
   end
   // Decodes at once, so the wait is pulled from the first strobe cycle
   assign channelReady = !(strobeOn && (seen_q ? cnt_q != 4'h0
                                                : waitLen != 4'h0));
   always @(posedge clk)
   begin
      seen_q <= strobeOn;
      if (strobeOn && !seen_q)
         cnt_q <= waitLen;
      else if (cnt_q != 4'h0)
         cnt_q <= cnt_q - 4'h1;
   end
   // Without keyboard takeover each card's lines are ANDed
   assign cardDetectAN = detSel ? detA : {&detB, &detA};
   // Card A sees the byte selects only through its buffer enable
   assign cardASelN = {cardHighByteSelN, cardLowByteSelN}
                      | {2{bufEnAN}};
endmodule
`default_nettype wire

// ===== test/cebp_pins_bench.sv
// Self-checking bench for the card and expansion bus pin logic
`timescale 1ns/1ps
`default_nettype none
module cebp_pins_bench;
   logic clk, rst, busEnable, wideIoPinSelect, detectPinSelect;
   logic bufEnAPinSelect, slotAIoMode, slotBIoMode, cycleReq, cycleIsIo;
   logic cycleWrite, cycleCard, cycleSlotB, cycleLowByte, cycleHighByte;
   logic coreDmaAck0N, channelCheckN, dmaRequest1, dmaRequest3, cardReadyA;
   logic kbdSerialInN, kbdClockN, cycleBusy, cycleDone, channelReady;
   logic ioReadStrobeN, ioReadStrobeOe, ioWriteStrobeN, ioWriteStrobeOe;
   logic cardLowByteSelN, cardHighByteSelN, dmaAck0N, dmaAck0Oe;
   logic nmiRequest, dmaReq1, dmaReq3, ioPortWide;
   logic [1:0] readyPinSelect, batteryPinSelect, cardBatteryStatusA;
   logic [1:0] detA, detB, cardDetectAN, cardIrq, cardReadyStatus;
   logic [1:0] cardPresent, statusChange, cardAudio;
   logic [3:0] statusDataBattery, waitLen;
   logic [5:0] periphIrqInputs, irqRequest;
   logic [4:0] seen, len;
   logic [1:0] cardASelN, seenA;
   logic [14:0] e;
   logic [14:0] expQ[$];
   logic [31:0] r;
   int miscompares, n_checks;

   cebp_pins dut_u (.clk, .rst, .busEnable, .readyPinSelect, .wideIoPinSelect,
      .batteryPinSelect, .detectPinSelect, .bufEnAPinSelect, .slotAIoMode,
      .slotBIoMode, .cycleReq, .cycleIsIo, .cycleWrite, .cycleCard,
      .cycleSlotB, .cycleLowByte, .cycleHighByte, .coreDmaAck0N, .cycleBusy,
      .cycleDone, .channelReady, .channelCheckN, .periphIrqInputs,
      .dmaRequest1, .dmaRequest3, .cardReadyA, .cardDetectAN, .kbdSerialInN,
      .kbdClockN, .cardBatteryStatusA, .ioReadStrobeN, .ioReadStrobeOe,
      .ioWriteStrobeN, .ioWriteStrobeOe, .cardLowByteSelN, .cardHighByteSelN,
      .dmaAck0N, .dmaAck0Oe, .nmiRequest, .irqRequest, .dmaReq1, .dmaReq3,
      .ioPortWide, .cardIrq, .cardReadyStatus, .cardPresent, .statusChange,
      .cardAudio, .statusDataBattery);
   cebp_far_model far_u (.clk, .ioReadStrobeN, .ioWriteStrobeN, .waitLen,
      .detSel(detectPinSelect), .detA, .detB, .cardLowByteSelN,
      .cardHighByteSelN, .bufEnAN(dmaAck0N), .channelReady, .cardDetectAN,
      .cardASelN);

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic final_report;
      $display("Checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_cycle(input logic [4:0] s, input logic [4:0] n,
                            input logic [14:0] x);
      n_checks++;
      if (s !== x[14:10] || n < x[9:5] || n > x[4:0])
      begin
         miscompares++;
         $display("Error at %0t: cycle pins %b length %0d", $time, s, n);
      end
   endtask

   // Strobes and selects seen low while busy, and cycle length
   // Sampled mid-cycle, clear of the edge that launches the outputs
   always @(negedge clk)
   begin
      if (cycleBusy === 1'b1)
      begin
         seen = seen | ~{ioReadStrobeN, ioWriteStrobeN, cardLowByteSelN,
                         cardHighByteSelN, dmaAck0N};
         seenA = seenA | ~cardASelN;
         len = len + 5'h01;
      end
      if (cycleDone === 1'b1)
      begin
         e = (expQ.size() > 0) ? expQ.pop_front() : 15'h7FFF;
         chk_cycle(seen, len, e);
         chk(seenA, {e[11] & e[10], e[12] & e[10]});
         seen = 5'h00;
         seenA = 2'h0;
         len = 5'h00;
      end
   end

   // a = {io, write, card, slotB, low, high}
   task automatic run_cycle(input logic [5:0] a, input logic [3:0] w);
      logic slow;
      slow = a[5] && w != 4'h0;
      @(posedge clk);
      #2;
      {cycleIsIo, cycleWrite, cycleCard, cycleSlotB, cycleLowByte,
       cycleHighByte} = a;
      waitLen = w;
      cycleReq = 1'b1;
      expQ.push_back({a[5] & !a[4], a[5] & a[4], a[3] & a[1], a[3] & a[0],
         a[3] & !a[2], slow ? 5'h05 : 5'h04, slow ? 5'h0E : 5'h04});
      @(posedge clk);
      #2;
      cycleReq = 1'b0;
      repeat (40)
         if (cycleBusy === 1'b1)
         begin
            @(posedge clk);
            #2;
         end
   endtask

   // Status pins need two sync stages plus one register
   task automatic settle;
      repeat (4) @(posedge clk);
      #2;
   endtask

   initial
   begin
      // Roughly 400 cycles of tests; generous margin
      #(5000 * 25);
      miscompares++;
      final_report;
   end

   initial
   begin
      void'($urandom(32'hC2045ECD));
      {rst, busEnable, channelCheckN, cardReadyA, coreDmaAck0N} = 5'h1F;
      {kbdSerialInN, kbdClockN, cardBatteryStatusA, detA, detB} = 8'hFF;
      {wideIoPinSelect, detectPinSelect, bufEnAPinSelect, slotAIoMode} = 4'h0;
      {slotBIoMode, cycleReq, dmaRequest1, dmaRequest3} = 4'h0;
      {cycleIsIo, cycleWrite, cycleCard, cycleSlotB} = 4'h0;
      {cycleLowByte, cycleHighByte, readyPinSelect, batteryPinSelect} = 6'h00;
      {periphIrqInputs, waitLen, seen, len} = 20'h00000;
      seenA = 2'h0;
      repeat (8) @(posedge clk);
      #2;
      rst = 1'b0;
      bufEnAPinSelect = 1'b1;
      for (int i = 0; i < 40; i++)
         run_cycle(6'($urandom), $urandom_range(1) ? 4'h6 : 4'h0);
      channelCheckN = 1'b0;
      periphIrqInputs = 6'h3F;
      settle;
      chk({nmiRequest, irqRequest}, 8'h7F);
      busEnable = 1'b0;
      {bufEnAPinSelect, coreDmaAck0N} = 2'h0;
      settle;
      chk({nmiRequest, irqRequest}, 8'h00);
      chk({ioReadStrobeOe, ioWriteStrobeOe}, 8'h00);
      chk({dmaAck0Oe, dmaAck0N}, 8'h00);
      {busEnable, wideIoPinSelect, periphIrqInputs} = 8'hC0;
      settle;
      chk({ioPortWide, nmiRequest}, 8'h02);
      chk({dmaAck0Oe, dmaAck0N}, 8'h02);
      {wideIoPinSelect, channelCheckN, readyPinSelect} = 4'h6;
      periphIrqInputs = 6'h3E;
      settle;
      chk({ioPortWide, irqRequest}, 8'h7E);
      {readyPinSelect, periphIrqInputs} = 8'h00;
      for (int k = 0; k < 8; k++)
      begin
         r = $urandom;
         {cardBatteryStatusA, dmaRequest1, dmaRequest3, cardReadyA} = r[4:0];
         {detA, detB} = r[8:5];
         {kbdClockN, kbdSerialInN} = r[6:5];
         batteryPinSelect = 2'(k);
         detectPinSelect = k[2];
         {slotAIoMode, slotBIoMode} = {k[1], k[1]};
         settle;
         chk(statusDataBattery, {batteryPinSelect[1] & dmaRequest3,
            batteryPinSelect[0] & dmaRequest1, cardBatteryStatusA});
         chk({dmaReq3, dmaReq1}, {dmaRequest3 & !batteryPinSelect[1],
            dmaRequest1 & !batteryPinSelect[0]});
         chk(cardPresent, k[2] ? {detB == 2'h0, detA == 2'h0}
            : {!(&detB), !(&detA)});
         chk({cardIrq, cardReadyStatus}, {1'b0, k[1] & !cardReadyA,
            !k[1], !k[1] & cardReadyA});
         chk({statusChange, cardAudio}, {k[1] & batteryPinSelect[0]
            & !dmaRequest1, k[1] & !cardBatteryStatusA[0], k[1]
            & batteryPinSelect[1] & !dmaRequest3,
            k[1] & !cardBatteryStatusA[1]});
      end
      chk(8'(expQ.size()), 8'h00);
      final_report;
   end
endmodule
`default_nettype wire
